// ==== spcc_ctrl.sv ====
// How it works
// - line polarity auto unless override set
// - user line polarity: 0 low, 1 high
// - line output polarity bit selects active level
// - line pulse starts on feedback tick, width clocks
// - frame source auto or pin/separator by select
// - frame polarity auto or user bit
// - frame output polarity bit selects active level
// - frame filter aligns frame sync to line sync
// - width enable picks register width or raw
// - frame width register, in line periods
// - freeze starts lead lines before frame sync
// - freeze holds tail lines after frame sync
// - freeze from internal window or pin
// - freeze pin polarity auto or user bit
// - clamp from internal timing or pin
// - clamp all channels while clamp active
// - line source pin or slicer by select when override set or both present, auto otherwise
// - clamp pin polarity auto or user bit
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module spcc_ctrl #(
    parameter int W = 22
) (
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        reset_n,
    // sync pins
    input  wire logic                        line_sync_in,
    input  wire logic                        sync_on_green_slicer_in,
    input  wire logic                        frame_sync_in,
    input  wire logic                        sep_frame_sync_in,
    input  wire logic                        freeze_in,
    input  wire logic                        clamp_in,
    // same-domain inputs
    input  wire logic                        fb_tick,
    input  wire logic                        int_clamp,
    // outputs
    output logic                             line_sync_out,
    output logic                             frame_sync_out,
    output logic                             freeze_out,
    output logic                             clamp_out,
    // axi4-lite
    input  wire logic [spcc_pkg::AXI_AW-1:0] awaddr,
    input  wire logic                        awvalid,
    output logic                             awready,
    input  wire logic [31:0]                 wdata,
    input  wire logic [3:0]                  wstrb,
    input  wire logic                        wvalid,
    output logic                             wready,
    output logic [1:0]                       bresp,
    output logic                             bvalid,
    input  wire logic                        bready,
    input  wire logic [spcc_pkg::AXI_AW-1:0] araddr,
    input  wire logic                        arvalid,
    output logic                             arready,
    output logic [31:0]                      rdata,
    output logic [1:0]                       rresp,
    output logic                             rvalid,
    input  wire logic                        rready
);
    import spcc_pkg::*;

    typedef struct packed {
        logic [N_IN-1:0]         s1;
        logic [N_IN-1:0]         s2;
        logic [N_IN-1:0]         s3;
        logic [N_IN-1:0][W-1:0]  hi;
        logic [N_IN-1:0][W-1:0]  lo;
        logic [N_IN-1:0][W-1:0]  idle;
        logic [N_IN-1:0]         pol;
        logic [7:0]              line_ctrl;
        logic [7:0]              line_width;
        logic [7:0]              frame_ctrl;
        logic [7:0]              frame_width;
        logic [7:0]              lead;
        logic [7:0]              tail;
        logic [7:0]              fc_ctrl;
        logic [7:0]              clamp_pol;
        logic                    ls_prev;
        logic                    ls_pulse;
        logic [7:0]              ls_cnt;
        logic                    ls_out;
        logic                    fs_filt;
        logic                    fs_prev;
        logic                    fs_wid;
        logic [7:0]              fs_cnt;
        logic                    fs_out;
        logic [11:0]             line_no;
        logic [11:0]             lines_frame;
        logic [7:0]              tail_cnt;
        logic                    frz_out;
        logic                    clp_out;
        spcc_wr_t                wr;
        logic                    aw_have;
        logic                    w_have;
        logic [7:0]              widx;
        logic                    walign;
        logic [7:0]              wbyte;
        logic                    wlane;
        logic                    awready;
        logic                    wready;
        logic                    bvalid;
        logic [1:0]              bresp;
        spcc_rd_t                rd;
        logic                    arready;
        logic                    rvalid;
        logic [7:0]              rdata;
        logic [1:0]              rresp;
    } spcc_st_t;

    spcc_st_t st_reg;
    spcc_st_t st_next;

    logic [N_IN-1:0] act;
    logic [7:0]      rd_idx;
    logic            both_ls, use_sog, use_sep, ls_pol, fs_pol, ls_act;
    logic            fs_act, ls_lead, fs_lead, fs_trail, pre_win, win;
    logic            frz_pol, clp_pol;

    // a sync counts as present while it toggled within the last 2^W clocks
    always_comb begin
        for (int i = 0; i < N_IN; i++) begin
            act[i] = ~&st_reg.idle[i];
        end
        both_ls = act[IN_LS] & act[IN_SOG];
        if (st_reg.line_ctrl[SRC_OVR] || both_ls) begin
            use_sog = st_reg.line_ctrl[SRC_SEL];
        end else begin
            use_sog = ~act[IN_LS] & act[IN_SOG];
        end
        if (st_reg.frame_ctrl[SRC_OVR]) begin
            use_sep = st_reg.frame_ctrl[SRC_SEL];
        end else begin
            use_sep = ~act[IN_FS] & act[IN_SEP];
        end
        if (st_reg.line_ctrl[POL_OVR]) begin
            ls_pol = st_reg.line_ctrl[POL_USR];
        end else begin
            ls_pol = use_sog ? st_reg.pol[IN_SOG] : st_reg.pol[IN_LS];
        end
        if (st_reg.frame_ctrl[POL_OVR]) begin
            fs_pol = st_reg.frame_ctrl[POL_USR];
        end else begin
            fs_pol = use_sep ? st_reg.pol[IN_SEP] : st_reg.pol[IN_FS];
        end
        ls_act = (use_sog ? st_reg.s2[IN_SOG] : st_reg.s2[IN_LS])
                 ~^ ls_pol;
        fs_act = (use_sep ? st_reg.s2[IN_SEP] : st_reg.s2[IN_FS])
                 ~^ fs_pol;
        ls_lead  = ls_act & ~st_reg.ls_prev;
        fs_lead  = st_reg.fs_filt & ~st_reg.fs_prev;
        fs_trail = ~st_reg.fs_filt & st_reg.fs_prev;
        // lead window guesses from last frame length; filters must match
        pre_win = (st_reg.lead != 8'h00) && (st_reg.lines_frame != 12'h000)
                  && ((st_reg.line_no + {4'h0, st_reg.lead})
                      >= st_reg.lines_frame);
        win = pre_win | st_reg.fs_filt
              | (st_reg.tail_cnt != 8'h00);
        frz_pol = st_reg.fc_ctrl[FZ_POL_OVR] ? st_reg.fc_ctrl[FZ_POL_USR]
                                             : st_reg.pol[IN_FRZ];
        clp_pol = st_reg.clamp_pol[CL_POL_OVR] ? st_reg.clamp_pol[CL_POL_USR]
                                               : st_reg.pol[IN_CLP];
    end

    function automatic logic [8:0] spcc_read(input logic [7:0] idx);
        logic [8:0] r;
        r = {1'b1, 8'h00};
        unique case (idx)
            IDX_LINE_CTRL:   r[7:0] = st_reg.line_ctrl;
            IDX_LINE_WIDTH:  r[7:0] = st_reg.line_width;
            IDX_FRAME_CTRL:  r[7:0] = st_reg.frame_ctrl;
            IDX_FRAME_WIDTH: r[7:0] = st_reg.frame_width;
            IDX_LEAD_LINES:  r[7:0] = st_reg.lead;
            IDX_TAIL_LINES:  r[7:0] = st_reg.tail;
            IDX_FRZ_CLAMP:   r[7:0] = st_reg.fc_ctrl;
            IDX_CLAMP_POL:   r[7:0] = st_reg.clamp_pol;
            IDX_STATUS:      r[7:0] = {use_sep, use_sog, st_reg.pol};
            default:         r[8]   = 1'b0;
        endcase
        return r;
    endfunction : spcc_read

    assign rd_idx = araddr[9:2];

    always_comb begin
        logic [8:0] rv;
        logic       hit;
        rv  = 9'h000;
        hit = 1'b0;
        st_next = st_reg;
        // pin synchronisers and per-input level timing
        st_next.s1 = {clamp_in, freeze_in, sep_frame_sync_in, frame_sync_in,
                      sync_on_green_slicer_in, line_sync_in};
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < N_IN; i++) begin
            if (st_reg.s2[i] != st_reg.s3[i]) begin
                st_next.idle[i] = '0;
            end else if (act[i]) begin
                st_next.idle[i] = st_reg.idle[i] + 1'b1;
            end
            if (st_reg.s2[i] && !st_reg.s3[i]) begin
                st_next.pol[i] = st_reg.hi[i] < st_reg.lo[i];
                st_next.hi[i]  = '0;
                st_next.lo[i]  = '0;
            end else if (st_reg.s2[i] && ~&st_reg.hi[i]) begin
                st_next.hi[i] = st_reg.hi[i] + 1'b1;
            end else if (!st_reg.s2[i] && ~&st_reg.lo[i]) begin
                st_next.lo[i] = st_reg.lo[i] + 1'b1;
            end
        end
        // regenerated line sync, leading edge on the feedback tick, width counted in clocks
        st_next.ls_prev = ls_act;
        if (fb_tick && st_reg.line_width != 8'h00) begin
            st_next.ls_pulse = 1'b1;
            st_next.ls_cnt   = 8'h01;
        end else if (st_reg.ls_pulse) begin
            if (st_reg.ls_cnt == st_reg.line_width) begin
                st_next.ls_pulse = 1'b0;
            end else begin
                st_next.ls_cnt = st_reg.ls_cnt + 8'h01;
            end
        end
        st_next.ls_out = st_next.ls_pulse ~^ st_reg.line_ctrl[OUT_POL];
        // frame sync filter and width shaping
        if (!st_reg.frame_ctrl[FS_FILT] || ls_lead) begin
            st_next.fs_filt = fs_act;
        end
        st_next.fs_prev = st_reg.fs_filt;
        if (fs_lead && st_reg.frame_width != 8'h00) begin
            st_next.fs_wid = 1'b1;
            st_next.fs_cnt = 8'h00;
        end else if (st_reg.fs_wid && ls_lead) begin
            if (st_reg.fs_cnt == st_reg.frame_width - 8'h01) begin
                st_next.fs_wid = 1'b0;
            end else begin
                st_next.fs_cnt = st_reg.fs_cnt + 8'h01;
            end
        end
        st_next.fs_out = (st_reg.frame_ctrl[FS_WIDEN] ? st_next.fs_wid
                                                      : st_next.fs_filt)
                         ~^ st_reg.frame_ctrl[OUT_POL];
        // freeze window built from line counts within a frame
        if (fs_lead) begin
            st_next.lines_frame = st_reg.line_no;
            st_next.line_no     = 12'h000;
        end else if (ls_lead && ~&st_reg.line_no) begin
            st_next.line_no = st_reg.line_no + 12'h001;
        end
        if (fs_trail) begin
            st_next.tail_cnt = st_reg.tail;
        end else if (ls_lead && st_reg.tail_cnt != 8'h00) begin
            st_next.tail_cnt = st_reg.tail_cnt - 8'h01;
        end
        st_next.frz_out = st_reg.fc_ctrl[FZ_SRC]
                          ? (st_reg.s2[IN_FRZ] ~^ frz_pol) : win;
        // placement and duration counting of internal clamp lives outside
        st_next.clp_out = st_reg.fc_ctrl[CL_SRC]
                          ? (st_reg.s2[IN_CLP] ~^ clp_pol)
                          : int_clamp;
        // write channel: address and data may arrive in either order
        if (st_reg.awready && awvalid) begin
            st_next.aw_have = 1'b1;
            st_next.widx    = awaddr[9:2];
            st_next.walign  = awaddr[1:0] == 2'b00;
        end
        if (st_reg.wready && wvalid) begin
            st_next.w_have = 1'b1;
            st_next.wbyte  = wdata[7:0];
            st_next.wlane  = wstrb[0];
        end
        unique case (st_reg.wr)
            SPCC_WR_IDLE: begin
                if (st_reg.aw_have && st_reg.w_have) begin
                    // a dropped lane or unaligned address is refused, no change
                    hit = st_reg.wlane && st_reg.walign;
                    if (st_reg.wlane && st_reg.walign) begin
                        unique case (st_reg.widx)
                            IDX_LINE_CTRL:   st_next.line_ctrl   = st_reg.wbyte;
                            IDX_LINE_WIDTH:  st_next.line_width  = st_reg.wbyte;
                            IDX_FRAME_CTRL:  st_next.frame_ctrl  = st_reg.wbyte;
                            IDX_FRAME_WIDTH: st_next.frame_width = st_reg.wbyte;
                            IDX_LEAD_LINES:  st_next.lead        = st_reg.wbyte;
                            IDX_TAIL_LINES:  st_next.tail        = st_reg.wbyte;
                            IDX_FRZ_CLAMP:   st_next.fc_ctrl     = st_reg.wbyte;
                            IDX_CLAMP_POL:   st_next.clamp_pol   = st_reg.wbyte;
                            IDX_STATUS:      hit = 1'b1;
                            default:         hit = 1'b0;
                        endcase
                    end
                    st_next.bresp   = hit ? RESP_OKAY : RESP_SLVERR;
                    st_next.bvalid  = 1'b1;
                    st_next.aw_have = 1'b0;
                    st_next.w_have  = 1'b0;
                    st_next.wr      = SPCC_WR_RESP;
                end
            end
            SPCC_WR_RESP: begin
                if (bready) begin
                    st_next.bvalid = 1'b0;
                    st_next.wr     = SPCC_WR_IDLE;
                end
            end
        endcase
        st_next.awready = !st_next.aw_have && st_next.wr == SPCC_WR_IDLE;
        st_next.wready  = !st_next.w_have && st_next.wr == SPCC_WR_IDLE;

        // read channel: one read in flight, answer one cycle after take
        unique case (st_reg.rd)
            SPCC_RD_IDLE: begin
                if (arvalid) begin
                    rv = spcc_read(rd_idx);
                    st_next.rdata   = rv[7:0];
                    st_next.rresp   = (rv[8] && araddr[1:0] == 2'b00)
                                      ? RESP_OKAY : RESP_SLVERR;
                    st_next.rvalid  = 1'b1;
                    st_next.arready = 1'b0;
                    st_next.rd      = SPCC_RD_DATA;
                end
            end
            SPCC_RD_DATA: begin
                if (rready) begin
                    st_next.rvalid  = 1'b0;
                    st_next.arready = 1'b1;
                    st_next.rd      = SPCC_RD_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg             <= '0;
            st_reg.pol         <= '1;
            st_reg.line_ctrl   <= LINE_CTRL_RST;
            st_reg.line_width  <= LINE_WIDTH_RST;
            st_reg.frame_ctrl  <= FRAME_CTRL_RST;
            st_reg.frame_width <= FRAME_WIDTH_RST;
            st_reg.lead        <= LEAD_LINES_RST;
            st_reg.tail        <= TAIL_LINES_RST;
            st_reg.fc_ctrl     <= FRZ_CLAMP_RST;
            st_reg.clamp_pol   <= CLAMP_POL_RST;
            st_reg.wr          <= SPCC_WR_IDLE;
            st_reg.rd          <= SPCC_RD_IDLE;
            st_reg.awready     <= 1'b1;
            st_reg.wready      <= 1'b1;
            st_reg.arready     <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign line_sync_out  = st_reg.ls_out;
    assign frame_sync_out = st_reg.fs_out;
    assign freeze_out     = st_reg.frz_out;
    assign clamp_out      = st_reg.clp_out;
    assign awready        = st_reg.awready;
    assign wready         = st_reg.wready;
    assign bvalid         = st_reg.bvalid;
    assign bresp          = st_reg.bresp;
    assign arready        = st_reg.arready;
    assign rvalid         = st_reg.rvalid;
    assign rresp          = st_reg.rresp;
    assign rdata          = {24'h000000, st_reg.rdata};
endmodule : spcc_ctrl
`default_nettype wire

// ==== spcc_ctrl_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module spcc_ctrl_chk (
    // clock and reset
    input wire logic                        ref_clk,
    input wire logic                        reset_n,
    // sync side
    input wire logic                        fb_tick,
    input wire logic                        int_clamp,
    input wire logic                        frame_sync_in,
    input wire logic                        sep_frame_sync_in,
    input wire logic                        freeze_in,
    input wire logic                        line_sync_out,
    input wire logic                        frame_sync_out,
    input wire logic                        freeze_out,
    input wire logic                        clamp_out,
    // register writes
    input wire logic [spcc_pkg::AXI_AW-1:0] awaddr,
    input wire logic                        awvalid,
    input wire logic                        awready,
    input wire logic [31:0]                 wdata,
    input wire logic                        wvalid,
    input wire logic                        wready,
    input wire logic [1:0]                  bresp,
    input wire logic                        bvalid,
    input wire logic                        bready
);
    import spcc_pkg::*;
    logic [9:0] a_q;
    logic [7:0] d_q, lc, wd, fr, fc, lcnt;
    logic [1:0] q;
    logic       ok, fsrc;
    assign ok   = (q == 2'h3);
    assign fsrc = fr[SRC_SEL] ? sep_frame_sync_in : frame_sync_in;
    // shadows lag the bus; ok masks cycles after writes
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            q    <= 2'h0;
            lcnt <= 8'h00;
            lc   <= LINE_CTRL_RST;
            wd   <= LINE_WIDTH_RST;
            fr   <= FRAME_CTRL_RST;
            fc   <= FRZ_CLAMP_RST;
        end else begin
            q    <= (awvalid || wvalid || bvalid) ? 2'h0 : (ok ? q : q + 2'h1);
            lcnt <= fb_tick ? wd : ((lcnt != 8'h00) ? lcnt - 8'h01 : lcnt);
            if (awvalid && awready) a_q <= awaddr;
            if (wvalid && wready) d_q <= wdata[7:0];
            if (bvalid && bready && bresp == RESP_OKAY) begin
                case (a_q[9:2])
                    IDX_LINE_CTRL:  lc <= d_q;
                    IDX_LINE_WIDTH: wd <= d_q;
                    IDX_FRAME_CTRL: fr <= d_q;
                    IDX_FRZ_CLAMP:  fc <= d_q;
                    default: ;
                endcase
            end
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    property p_lvl; ok |-> line_sync_out == ((lcnt != 8'h00) == lc[OUT_POL]);
    endproperty
    a_lvl: assert property (p_lvl) else $error("line level");
    property p_start; ok && fb_tick && wd != 8'h00 |=> line_sync_out == lc[OUT_POL];
    endproperty
    a_start: assert property (p_start) else $error("line start");
    property p_zero; ok && fb_tick && wd == 8'h00 |=> line_sync_out != lc[OUT_POL];
    endproperty
    a_zero: assert property (p_zero) else $error("line zero width");
    property p_end; ok && lcnt == 8'h01 && !fb_tick |=> line_sync_out != lc[OUT_POL];
    endproperty
    a_end: assert property (p_end) else $error("line end");
    property p_hold; ok && fb_tick && wd > 8'h03 |=> (line_sync_out == lc[OUT_POL])[*3];
    endproperty
    a_hold: assert property (p_hold) else $error("line hold");
    property p_clmp; ok && !fc[CL_SRC] |-> clamp_out == $past(int_clamp);
    endproperty
    a_clmp: assert property (p_clmp) else $error("internal clamp");
    property p_frm;
        (ok && fr[SRC_OVR] && fr[POL_OVR] && !fr[FS_FILT] && !fr[FS_WIDEN]
         && $stable(fsrc))[*6] |->
            frame_sync_out == ((fsrc == fr[POL_USR]) == fr[OUT_POL]);
    endproperty
    a_frm: assert property (p_frm) else $error("frame sync out");
    property p_frz;
        (ok && fc[FZ_SRC] && fc[FZ_POL_OVR] && $stable(freeze_in))[*6] |->
            freeze_out == (freeze_in == fc[FZ_POL_USR]);
    endproperty
    a_frz: assert property (p_frz) else $error("freeze pin");
endmodule : spcc_ctrl_chk
bind spcc_ctrl spcc_ctrl_chk u_chk (.*);
`default_nettype wire

// ==== spcc_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module spcc_ctrl_tb;
    import spcc_pkg::*;
    logic ref_clk, reset_n, fb_tick, int_clamp, line_sync_in, frame_sync_in;
    logic sync_on_green_slicer_in, sep_frame_sync_in, freeze_in, clamp_in;
    logic line_sync_out, frame_sync_out, freeze_out, clamp_out, ic;
    logic awvalid, awready, wvalid, wready, bvalid, bready, run, act_hi;
    logic arvalid, arready, rvalid, rready, lvl;
    logic [AXI_AW-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp, rsp;
    logic [7:0]        v, e;
    logic [2:0]        b;
    int                n_errors, checks, cnt;
    localparam logic [7:0] IX [8] = '{IDX_LINE_CTRL, IDX_LINE_WIDTH,
        IDX_FRAME_CTRL, IDX_FRAME_WIDTH, IDX_LEAD_LINES, IDX_TAIL_LINES,
        IDX_FRZ_CLAMP, IDX_CLAMP_POL};
    localparam logic [7:0] RV [8] = '{8'h18, LINE_WIDTH_RST, 8'h18, 8'h0A,
        8'h00, 8'h00, 8'h20, 8'h40};
    spcc_ctrl #(.W(10)) u_dut (.*);
    spcc_src_model u_src (.*);
    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [9:0] a, input logic [7:0] d,
                      input logic [3:0] s);
        @(posedge ref_clk);
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        wstrb   <= s;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        rsp = bresp;
        bready <= 1'h0;
    endtask : wr
    task automatic rd(input logic [9:0] a);
        @(posedge ref_clk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        v = rdata[7:0];
        rsp = rresp;
        rready <= 1'h0;
    endtask : rd
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report
    initial begin
        #500000;
        n_errors++;
        final_report();
    end
    initial begin
        void'($urandom(44));
        {reset_n, fb_tick, int_clamp, sync_on_green_slicer_in, run, act_hi,
         sep_frame_sync_in, freeze_in, clamp_in, awvalid, wvalid, bready,
         arvalid, rready, lvl} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (16) @(posedge ref_clk);
        reset_n <= 1'h1;
        for (int i = 0; i < 8; i++) begin
            rd({IX[i], 2'h0});
            chk(v, RV[i]);
        end
        wr({IDX_LEAD_LINES, 2'h0}, 8'h77, 4'h0);
        chk(rsp, RESP_SLVERR);
        rd({IDX_LEAD_LINES, 2'h0});
        chk(v, 8'h00);
        wr({8'h30, 2'h0}, 8'h55, 4'hF);
        chk(rsp, RESP_SLVERR);
        rd({IDX_TAIL_LINES, 2'h1});
        chk(rsp, RESP_SLVERR);
        for (int i = 0; i < 8; i++) begin
            e = 8'($urandom());
            wr({IX[i], 2'h0}, e, 4'hF);
            chk(rsp, RESP_OKAY);
            rd({IX[i], 2'h0});
            chk(v, e);
        end
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            e = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'hFF
                : 8'($urandom_range(2, 60));
            wr({IDX_LINE_CTRL, 2'h0}, {4'h1, i[0], 3'h0}, 4'hF);
            wr({IDX_LINE_WIDTH, 2'h0}, e, 4'hF);
            repeat (4) @(posedge ref_clk);
            fb_tick <= 1'h1;
            @(posedge ref_clk);
            fb_tick <= 1'h0;
            cnt = 0;
            repeat (270) begin
                @(posedge ref_clk);
                if (line_sync_out === i[0]) cnt++;
            end
            chk(cnt, e);
        end
        for (int j = 0; j < 2; j++) begin
            wr({IDX_LINE_CTRL, 2'h0}, {1'h1, j[0], 6'h18}, 4'hF);
            rd({IDX_STATUS, 2'h0});
            chk(v[6], j[0]);
        end
        $display("test line sync done");
        for (int i = 0; i < 8; i++) begin
            b = i[2:0];
            wr({IDX_FRAME_CTRL, 2'h0}, {1'h1, b[2], 1'h1, b[1:0], 3'h0}, 4'hF);
            lvl               <= 1'($urandom());
            sep_frame_sync_in <= 1'($urandom());
            repeat (10) @(posedge ref_clk);
            e[0] = ((b[2] ? sep_frame_sync_in : lvl) == b[1]) == b[0];
            chk(frame_sync_out, e[0]);
            rd({IDX_STATUS, 2'h0});
            chk(v[7], b[2]);
        end
        for (int i = 0; i < 4; i++) begin
            wr({IDX_FRZ_CLAMP, 2'h0}, {2'h3, i[0], 1'h1, 4'h0}, 4'hF);
            wr({IDX_CLAMP_POL, 2'h0}, {1'h1, i[1], 6'h03}, 4'hF);
            freeze_in <= 1'($urandom());
            clamp_in  <= 1'($urandom());
            repeat (10) @(posedge ref_clk);
            chk(freeze_out, freeze_in == i[0]);
            chk(clamp_out, clamp_in == i[1]);
        end
        wr({IDX_FRZ_CLAMP, 2'h0}, 8'h20, 4'hF);
        for (int k = 0; k < 40; k++) begin
            @(posedge ref_clk);
            if (k > 1) chk(clamp_out, ic);
            ic = int_clamp;
            int_clamp <= 1'($urandom());
        end
        $display("test frame freeze clamp done");
        for (int a = 0; a < 2; a++) begin
            wr({IDX_FRAME_CTRL, 2'h0}, 8'h88, 4'hF);
            act_hi <= a[0];
            run    <= 1'h1;
            repeat (1500) @(posedge ref_clk);
            cnt = 0;
            repeat (640) begin
                @(posedge ref_clk);
                if (frame_sync_out === 1'h1) cnt++;
            end
            chk(cnt < 320, 1'h1);
        end
        $display("test auto polarity done");
        final_report();
    end
endmodule : spcc_ctrl_tb
`default_nettype wire

// ==== spcc_pkg.sv ====
package spcc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_LINE_CTRL   = 8'h12;
    localparam logic [7:0] IDX_LINE_WIDTH  = 8'h13;
    localparam logic [7:0] IDX_FRAME_CTRL  = 8'h14;
    localparam logic [7:0] IDX_FRAME_WIDTH = 8'h15;
    localparam logic [7:0] IDX_LEAD_LINES  = 8'h16;
    localparam logic [7:0] IDX_TAIL_LINES  = 8'h17;
    localparam logic [7:0] IDX_FRZ_CLAMP   = 8'h18;
    localparam logic [7:0] IDX_CLAMP_POL   = 8'h1B;
    localparam logic [7:0] IDX_STATUS      = 8'h21;

    // field positions shared by line and frame control; FS_FILT, FS_WIDEN frame only
    localparam int SRC_OVR  = 7;
    localparam int SRC_SEL  = 6;
    localparam int POL_OVR  = 5;
    localparam int POL_USR  = 4;
    localparam int OUT_POL  = 3;
    localparam int FS_FILT  = 2;
    localparam int FS_WIDEN = 1;
    // freeze / clamp control
    localparam int FZ_SRC     = 7;
    localparam int FZ_POL_OVR = 6;
    localparam int FZ_POL_USR = 5;
    localparam int CL_SRC     = 4;
    localparam int CL_POL_OVR = 7;
    localparam int CL_POL_USR = 6;

    // reset values
    localparam logic [7:0] LINE_CTRL_RST   = 8'h18;
    localparam logic [7:0] LINE_WIDTH_RST  = 8'h20;
    localparam logic [7:0] FRAME_CTRL_RST  = 8'h18;
    localparam logic [7:0] FRAME_WIDTH_RST = 8'h0A;
    localparam logic [7:0] LEAD_LINES_RST  = 8'h00;
    localparam logic [7:0] TAIL_LINES_RST  = 8'h00;
    localparam logic [7:0] FRZ_CLAMP_RST   = 8'h20;
    localparam logic [7:0] CLAMP_POL_RST   = 8'h40;

    // sync input slots
    localparam int IN_LS  = 0;
    localparam int IN_SOG = 1;
    localparam int IN_FS  = 2;
    localparam int IN_SEP = 3;
    localparam int IN_FRZ = 4;
    localparam int IN_CLP = 5;
    localparam int N_IN   = 6;

    // bus
    localparam int         AXI_AW      = 10;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        SPCC_WR_IDLE = 2'b01,
        SPCC_WR_RESP = 2'b10
    } spcc_wr_t;

    typedef enum logic [1:0] {
        SPCC_RD_IDLE = 2'b01,
        SPCC_RD_DATA = 2'b10
    } spcc_rd_t;
endpackage : spcc_pkg

// ==== spcc_src_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module spcc_src_model (
    // clock
    input  wire logic ref_clk,
    // bench control
    input  wire logic run,
    input  wire logic act_hi,
    input  wire logic lvl,
    // sync pins
    output logic      line_sync_in,
    output logic      frame_sync_in
);
    int unsigned n = 0;
    initial {line_sync_in, frame_sync_in} = 2'h0;
    // 40-clock lines, 8-line frames; stopped, pins park on lvl
    always @(posedge ref_clk) begin
        n             <= (n + 1) % 320;
        line_sync_in  <= run ? ((n % 40 < 4) == act_hi) : lvl;
        frame_sync_in <= run ? ((n < 40) == act_hi) : lvl;
    end
endmodule : spcc_src_model
`default_nettype wire
